// File: core/bsle_pkg.sv
package bsle_pkg;

   // ----------------------------------------------------------------
   // operations handed to the executer
   // ----------------------------------------------------------------
   typedef enum logic [5:0]
   {
      OP_COMPARE_SKIP_EQUAL = 6'h00,
      OP_COMPARE_REGS = 6'h01,
      OP_COMPARE_REGS_WITH_CARRY = 6'h02,
      OP_COMPARE_IMMEDIATE = 6'h03,
      OP_SKIP_REG_BIT_CLEAR = 6'h04,
      OP_SKIP_REG_BIT_SET = 6'h05,
      OP_SKIP_IO_BIT_CLEAR = 6'h06,
      OP_SKIP_IO_BIT_SET = 6'h07,
      OP_BRANCH_FLAG_SET = 6'h08,
      OP_BRANCH_FLAG_CLEAR = 6'h09,
      OP_BRANCH_EQUAL = 6'h0a,
      OP_BRANCH_NOT_EQUAL = 6'h0b,
      OP_BRANCH_CARRY_SET = 6'h0c,
      OP_BRANCH_CARRY_CLEAR = 6'h0d,
      OP_BRANCH_SAME_OR_HIGHER = 6'h0e,
      OP_BRANCH_LOWER = 6'h0f,
      OP_BRANCH_MINUS = 6'h10,
      OP_BRANCH_PLUS = 6'h11,
      OP_BRANCH_SIGNED_GE = 6'h12,
      OP_BRANCH_SIGNED_LT = 6'h13,
      OP_BRANCH_HALF_CARRY_SET = 6'h14,
      OP_BRANCH_HALF_CARRY_CLEAR = 6'h15,
      OP_BRANCH_TBIT_SET = 6'h16,
      OP_BRANCH_TBIT_CLEAR = 6'h17,
      OP_BRANCH_OVERFLOW_SET = 6'h18,
      OP_BRANCH_OVERFLOW_CLEAR = 6'h19,
      OP_BRANCH_IRQ_ENABLED = 6'h1a,
      OP_BRANCH_IRQ_DISABLED = 6'h1b,
      OP_DIRECT_BYTE_FETCH = 6'h1c,
      OP_POINTER_BYTE_FETCH = 6'h1d,
      OP_POINTER_FETCH_INC = 6'h1e,
      OP_POINTER_FETCH_DEC = 6'h1f,
      OP_ABSOLUTE_CALL = 6'h20,
      OP_SUBROUTINE_EXIT = 6'h21,
      OP_INTERRUPT_EXIT = 6'h22
   } bsle_op_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_WB = 2'b10
   } bsle_state_t;

   // ----------------------------------------------------------------
   // status flag positions and reset values
   // ----------------------------------------------------------------
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;
   localparam logic [7:0] STATUS_FLAGS_REGISTER_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] SP_RESET = 16'h0fff;
   localparam logic [15:0] IO_BASE = 16'h0000;

   // ----------------------------------------------------------------
   // pointer pairs: low byte register index
   // ----------------------------------------------------------------
   localparam logic [1:0] PTR_SEL_X = 2'h0;
   localparam logic [1:0] PTR_SEL_Y = 2'h1;
   localparam logic [4:0] PTR_X_LO = 5'h1a;
   localparam logic [4:0] PTR_Y_LO = 5'h1c;
   localparam logic [4:0] PTR_Z_LO = 5'h1e;

   // ----------------------------------------------------------------
   // cycle counts
   // ----------------------------------------------------------------
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_THREE = 3'h3;
   localparam logic [2:0] CYC_FOUR = 3'h4;
   localparam logic [2:0] CYC_CALL = 3'h3;
   localparam logic [2:0] CYC_EXIT = 3'h4;

   // ----------------------------------------------------------------
   // compare: difference flags, nothing written back
   // ----------------------------------------------------------------
   function automatic logic [7:0] cmp_flags(input logic [7:0] d,
      input logic [7:0] r, input logic cin, input logic chain,
      input logic [7:0] sr);
      logic [7:0] res;
      logic [7:0] f;
      res = d - r - {7'h00, cin};
      f = sr;
      f[FLG_H] = (~d[3] & r[3]) | (r[3] & res[3]) | (res[3] & ~d[3]);
      f[FLG_C] = (~d[7] & r[7]) | (r[7] & res[7]) | (res[7] & ~d[7]);
      f[FLG_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
      f[FLG_N] = res[7];
      f[FLG_S] = res[7] ^ f[FLG_V];
      f[FLG_Z] = (res == 8'h00) & (~chain | sr[FLG_Z]);
      return f;
   endfunction

   function automatic logic is_branch(input bsle_op_t op);
      return (op >= OP_BRANCH_FLAG_SET) && (op <= OP_BRANCH_IRQ_DISABLED);
   endfunction

   function automatic logic branch_cond(input bsle_op_t op,
      input logic [2:0] s, input logic [7:0] sr);
      logic v;
      v = 1'b0;
      case (op)
         OP_BRANCH_FLAG_SET: v = sr[s];
         OP_BRANCH_FLAG_CLEAR: v = ~sr[s];
         OP_BRANCH_EQUAL: v = sr[FLG_Z];
         OP_BRANCH_NOT_EQUAL: v = ~sr[FLG_Z];
         OP_BRANCH_CARRY_SET: v = sr[FLG_C];
         OP_BRANCH_LOWER: v = sr[FLG_C];
         OP_BRANCH_CARRY_CLEAR: v = ~sr[FLG_C];
         OP_BRANCH_SAME_OR_HIGHER: v = ~sr[FLG_C];
         OP_BRANCH_MINUS: v = sr[FLG_N];
         OP_BRANCH_PLUS: v = ~sr[FLG_N];
         OP_BRANCH_SIGNED_GE: v = ~(sr[FLG_N] ^ sr[FLG_V]);
         OP_BRANCH_SIGNED_LT: v = sr[FLG_N] ^ sr[FLG_V];
         OP_BRANCH_HALF_CARRY_SET: v = sr[FLG_H];
         OP_BRANCH_HALF_CARRY_CLEAR: v = ~sr[FLG_H];
         OP_BRANCH_TBIT_SET: v = sr[FLG_T];
         OP_BRANCH_TBIT_CLEAR: v = ~sr[FLG_T];
         OP_BRANCH_OVERFLOW_SET: v = sr[FLG_V];
         OP_BRANCH_OVERFLOW_CLEAR: v = ~sr[FLG_V];
         OP_BRANCH_IRQ_ENABLED: v = sr[FLG_I];
         OP_BRANCH_IRQ_DISABLED: v = ~sr[FLG_I];
         default: v = 1'b0;
      endcase
      return v;
   endfunction

endpackage

// File: core/bsle_regfile.sv
`timescale 1ns/1ps
module bsle_regfile (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // read ports
   input wire logic rd_en,
   input wire logic [4:0] ra_addr,
   input wire logic [4:0] rb_addr,
   output logic [7:0] ra_q,
   output logic [7:0] rb_q,
   // byte write
   input wire logic wa_en,
   input wire logic [4:0] wa_addr,
   input wire logic [7:0] wa_data,
   // pair write, even index
   input wire logic wb_en,
   input wire logic [3:0] wb_pair,
   input wire logic [15:0] wb_data
);

   logic [7:0] mem [0:31];

   always_ff @(posedge core_clk)
   begin
      if (wa_en)
      begin
         mem[wa_addr] <= wa_data;
      end
      if (wb_en)
      begin
         mem[{wb_pair, 1'b0}] <= wb_data[7:0];
         mem[{wb_pair, 1'b1}] <= wb_data[15:8];
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ra_q <= 8'h00;
         rb_q <= 8'h00;
      end
      else if (rd_en)
      begin
         ra_q <= mem[ra_addr];
         rb_q <= mem[rb_addr];
      end
   end

endmodule // bsle_regfile

// File: core/bsle_core.sv
// Contract
// - equal registers skip next instruction, no flags
// - compares set six flags, no writeback
// - register bit test skips next instruction
// - io bit test skips, two to four cycles
// - generic flag branch to pc plus k plus one
// - signed branches use negative xor overflow
// - unsigned and carry branches test carry
// - half carry branches test half carry
// - t flag branches test transfer bit
// - overflow branches test overflow flag
// - interrupt branches test global enable
// - direct load copies byte in two cycles
// - post increment load reads then increments
// - pre decrement load decrements then reads
`timescale 1ns/1ps
module bsle_core (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // instruction issue
   input wire logic instr_valid,
   input wire logic [5:0] instr_op,
   input wire logic [4:0] instr_d,
   input wire logic [4:0] instr_r,
   input wire logic [7:0] instr_imm,
   input wire logic [2:0] instr_bit,
   input wire logic [6:0] instr_k,
   input wire logic [15:0] instr_addr,
   input wire logic [1:0] instr_ptr,
   input wire logic next_two_word,
   output logic instr_ready_q,
   output logic done_q,
   // state view
   output logic [15:0] pc_q,
   output logic [7:0] status_flags_register_q,
   // preload while idle
   input wire logic ext_wr_en,
   input wire logic [4:0] ext_wr_addr,
   input wire logic [7:0] ext_wr_data,
   input wire logic status_flags_register_wr_en,
   input wire logic [7:0] status_flags_register_wr_data,
   // data and io space
   output logic [15:0] dbus_addr_q,
   output logic dbus_rd_q,
   input wire logic [7:0] dbus_rdata
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bsle_pkg::bsle_state_t state_q;
   bsle_pkg::bsle_op_t op_q;
   logic [2:0] cnt_q;
   logic take_q;
   logic two_q;
   logic [4:0] d_q;
   logic [7:0] imm_q;
   logic [2:0] bit_q;
   logic [6:0] k_q;
   logic [15:0] addr_q;
   logic [15:0] sp_q;
   logic [7:0] hi_q;
   logic [7:0] ra_q;
   logic [7:0] rb_q;
   logic accept;
   logic [4:0] ptr_lo;
   logic ptr_op;
   logic [15:0] ptr;
   logic dec_now;
   logic cond;
   logic take;
   logic [2:0] len;
   logic last;
   logic wa_en;
   logic [4:0] wa_addr;
   logic [7:0] wa_data;
   logic wb_en;
   logic [15:0] wb_data;

   assign accept = instr_valid & instr_ready_q;
   assign ptr_lo = (instr_ptr == bsle_pkg::PTR_SEL_X) ? bsle_pkg::PTR_X_LO :
      (instr_ptr == bsle_pkg::PTR_SEL_Y) ? bsle_pkg::PTR_Y_LO :
      bsle_pkg::PTR_Z_LO;
   assign ptr_op = (instr_op >= 6'h1d) && (instr_op <= 6'h1f);
   assign ptr = {rb_q, ra_q};

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   bsle_regfile u_rf (
      .core_clk(core_clk),
      .nrst(nrst),
      .rd_en(accept),
      .ra_addr(ptr_op ? ptr_lo : instr_d),
      .rb_addr(ptr_op ? ptr_lo + 5'h01 : instr_r),
      .ra_q(ra_q),
      .rb_q(rb_q),
      .wa_en(wa_en),
      .wa_addr(wa_addr),
      .wa_data(wa_data),
      .wb_en(wb_en),
      .wb_pair(addr_q[4:1]),
      .wb_data(wb_data)
   );

   // ----------------------------------------------------------------
   // decision and length
   // ----------------------------------------------------------------
   always_comb
   begin
      dec_now = (cnt_q == 3'h0);
      cond = 1'b0;
      len = bsle_pkg::CYC_ONE;
      case (op_q)
         bsle_pkg::OP_COMPARE_SKIP_EQUAL: cond = (ra_q == rb_q);
         bsle_pkg::OP_SKIP_REG_BIT_CLEAR: cond = ~rb_q[bit_q];
         bsle_pkg::OP_SKIP_REG_BIT_SET: cond = rb_q[bit_q];
         bsle_pkg::OP_SKIP_IO_BIT_CLEAR:
         begin
            dec_now = (cnt_q == 3'h1);
            cond = ~dbus_rdata[bit_q];
         end
         bsle_pkg::OP_SKIP_IO_BIT_SET:
         begin
            dec_now = (cnt_q == 3'h1);
            cond = dbus_rdata[bit_q];
         end
         default:
         begin
            cond = bsle_pkg::branch_cond(op_q, bit_q, status_flags_register_q);
         end
      endcase
      take = dec_now ? cond : take_q;
      if (op_q <= bsle_pkg::OP_SKIP_REG_BIT_SET)
      begin
         if (op_q == bsle_pkg::OP_COMPARE_SKIP_EQUAL ||
             op_q >= bsle_pkg::OP_SKIP_REG_BIT_CLEAR)
         begin
            len = !take ? bsle_pkg::CYC_ONE :
               two_q ? bsle_pkg::CYC_THREE : bsle_pkg::CYC_TWO;
         end
      end
      else if (op_q <= bsle_pkg::OP_SKIP_IO_BIT_SET)
      begin
         len = !take ? bsle_pkg::CYC_TWO :
            two_q ? bsle_pkg::CYC_FOUR : bsle_pkg::CYC_THREE;
      end
      else if (bsle_pkg::is_branch(op_q))
      begin
         len = take ? bsle_pkg::CYC_TWO : bsle_pkg::CYC_ONE;
      end
      else if (op_q == bsle_pkg::OP_DIRECT_BYTE_FETCH)
      begin
         len = bsle_pkg::CYC_TWO;
      end
      else if (op_q == bsle_pkg::OP_POINTER_FETCH_DEC)
      begin
         len = bsle_pkg::CYC_TWO;
      end
      else if (op_q == bsle_pkg::OP_ABSOLUTE_CALL)
      begin
         len = bsle_pkg::CYC_CALL;
      end
      else if (op_q >= bsle_pkg::OP_SUBROUTINE_EXIT)
      begin
         len = bsle_pkg::CYC_EXIT;
      end
      last = (state_q == bsle_pkg::ST_EXEC) && (cnt_q == len - 3'h1);
   end

   // ----------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= bsle_pkg::ST_IDLE;
         cnt_q <= 3'h0;
         instr_ready_q <= 1'b1;
         done_q <= 1'b0;
         take_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            bsle_pkg::ST_IDLE:
            begin
               if (accept)
               begin
                  state_q <= bsle_pkg::ST_EXEC;
                  instr_ready_q <= 1'b0;
                  cnt_q <= 3'h0;
               end
            end
            bsle_pkg::ST_EXEC:
            begin
               if (dec_now)
               begin
                  take_q <= cond;
               end
               cnt_q <= cnt_q + 3'h1;
               if (last)
               begin
                  if (op_q == bsle_pkg::OP_POINTER_BYTE_FETCH ||
                      op_q == bsle_pkg::OP_POINTER_FETCH_INC ||
                      op_q == bsle_pkg::OP_POINTER_FETCH_DEC)
                  begin
                     state_q <= bsle_pkg::ST_WB;
                  end
                  else
                  begin
                     state_q <= bsle_pkg::ST_IDLE;
                     instr_ready_q <= 1'b1;
                     done_q <= 1'b1;
                  end
               end
            end
            default:
            begin
               state_q <= bsle_pkg::ST_IDLE;
               instr_ready_q <= 1'b1;
               done_q <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // operand capture
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         op_q <= bsle_pkg::OP_COMPARE_REGS;
         two_q <= 1'b0;
         d_q <= 5'h00;
         imm_q <= 8'h00;
         bit_q <= 3'h0;
         k_q <= 7'h00;
         addr_q <= 16'h0000;
      end
      else if (accept)
      begin
         op_q <= bsle_pkg::bsle_op_t'(instr_op);
         two_q <= next_two_word;
         d_q <= instr_d;
         imm_q <= instr_imm;
         bit_q <= instr_bit;
         k_q <= instr_k;
         addr_q <= ptr_op ? {11'h000, ptr_lo} : instr_addr;
      end
   end

   // ----------------------------------------------------------------
   // program counter and stack
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pc_q <= bsle_pkg::PC_RESET;
         sp_q <= bsle_pkg::SP_RESET;
         hi_q <= 8'h00;
      end
      else if (state_q == bsle_pkg::ST_EXEC)
      begin
         if (op_q >= bsle_pkg::OP_SUBROUTINE_EXIT && cnt_q == 3'h2)
         begin
            hi_q <= dbus_rdata;
         end
         if (last)
         begin
            if (op_q <= bsle_pkg::OP_SKIP_IO_BIT_SET)
            begin
               if (op_q == bsle_pkg::OP_COMPARE_SKIP_EQUAL ||
                   op_q >= bsle_pkg::OP_SKIP_REG_BIT_CLEAR)
               begin
                  pc_q <= pc_q + (!take ? 16'h0001 :
                     two_q ? 16'h0003 : 16'h0002);
               end
               else
               begin
                  pc_q <= pc_q + 16'h0001;
               end
            end
            else if (bsle_pkg::is_branch(op_q))
            begin
               pc_q <= take ? pc_q + {{9{k_q[6]}}, k_q} + 16'h0001 :
                  pc_q + 16'h0001;
            end
            else if (op_q == bsle_pkg::OP_DIRECT_BYTE_FETCH)
            begin
               pc_q <= pc_q + 16'h0002;
            end
            else if (op_q == bsle_pkg::OP_ABSOLUTE_CALL)
            begin
               pc_q <= addr_q;
            end
            else if (op_q >= bsle_pkg::OP_SUBROUTINE_EXIT)
            begin
               pc_q <= {hi_q, dbus_rdata};
               sp_q <= sp_q + 16'h0002;
            end
            else
            begin
               pc_q <= pc_q + 16'h0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // status flags
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         status_flags_register_q <= bsle_pkg::STATUS_FLAGS_REGISTER_RESET;
      end
      else if (state_q == bsle_pkg::ST_IDLE)
      begin
         if (status_flags_register_wr_en)
         begin
            status_flags_register_q <= status_flags_register_wr_data;
         end
      end
      else if (state_q == bsle_pkg::ST_EXEC)
      begin
         if (op_q == bsle_pkg::OP_COMPARE_REGS)
         begin
            status_flags_register_q <= bsle_pkg::cmp_flags(ra_q, rb_q, 1'b0, 1'b0,
               status_flags_register_q);
         end
         else if (op_q == bsle_pkg::OP_COMPARE_REGS_WITH_CARRY)
         begin
            status_flags_register_q <= bsle_pkg::cmp_flags(ra_q, rb_q,
               status_flags_register_q[bsle_pkg::FLG_C], 1'b1, status_flags_register_q);
         end
         else if (op_q == bsle_pkg::OP_COMPARE_IMMEDIATE)
         begin
            status_flags_register_q <= bsle_pkg::cmp_flags(ra_q, imm_q, 1'b0, 1'b0,
               status_flags_register_q);
         end
         else if (op_q == bsle_pkg::OP_INTERRUPT_EXIT && last)
         begin
            status_flags_register_q[bsle_pkg::FLG_I] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // data space reads
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dbus_addr_q <= 16'h0000;
         dbus_rd_q <= 1'b0;
      end
      else
      begin
         dbus_rd_q <= 1'b0;
         if (state_q == bsle_pkg::ST_EXEC && cnt_q == 3'h0)
         begin
            if (op_q == bsle_pkg::OP_SKIP_IO_BIT_CLEAR ||
                op_q == bsle_pkg::OP_SKIP_IO_BIT_SET)
            begin
               dbus_addr_q <= bsle_pkg::IO_BASE + addr_q;
               dbus_rd_q <= 1'b1;
            end
            else if (op_q == bsle_pkg::OP_DIRECT_BYTE_FETCH)
            begin
               dbus_addr_q <= addr_q;
               dbus_rd_q <= 1'b1;
            end
            else if (op_q == bsle_pkg::OP_POINTER_BYTE_FETCH ||
                     op_q == bsle_pkg::OP_POINTER_FETCH_INC)
            begin
               dbus_addr_q <= ptr;
               dbus_rd_q <= 1'b1;
            end
         end
         else if (state_q == bsle_pkg::ST_EXEC && cnt_q == 3'h1)
         begin
            if (op_q == bsle_pkg::OP_POINTER_FETCH_DEC)
            begin
               dbus_addr_q <= ptr - 16'h0001;
               dbus_rd_q <= 1'b1;
            end
            else if (op_q >= bsle_pkg::OP_SUBROUTINE_EXIT)
            begin
               dbus_addr_q <= sp_q + 16'h0001;
               dbus_rd_q <= 1'b1;
            end
         end
         else if (state_q == bsle_pkg::ST_EXEC && cnt_q == 3'h2 &&
                  op_q >= bsle_pkg::OP_SUBROUTINE_EXIT)
         begin
            // low byte read lands on the last exec edge
            dbus_addr_q <= sp_q + 16'h0002;
            dbus_rd_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always_comb
   begin
      wa_en = 1'b0;
      wa_addr = d_q;
      wa_data = dbus_rdata;
      wb_en = 1'b0;
      wb_data = ptr + 16'h0001;
      if (state_q == bsle_pkg::ST_IDLE)
      begin
         wa_en = ext_wr_en & ~accept;
         wa_addr = ext_wr_addr;
         wa_data = ext_wr_data;
      end
      else if (state_q == bsle_pkg::ST_WB)
      begin
         wa_en = 1'b1;
      end
      else if (op_q == bsle_pkg::OP_DIRECT_BYTE_FETCH && cnt_q == 3'h1)
      begin
         wa_en = 1'b1;
      end
      else if (op_q == bsle_pkg::OP_POINTER_FETCH_INC && cnt_q == 3'h0)
      begin
         wb_en = 1'b1;
      end
      else if (op_q == bsle_pkg::OP_POINTER_FETCH_DEC && cnt_q == 3'h0)
      begin
         wb_en = 1'b1;
         wb_data = ptr - 16'h0001;
      end
   end

endmodule // bsle_core

// File: sim/bsle_mem_model.sv
`timescale 1ns/1ps
module bsle_mem_model (
   // data space read port
   input wire logic core_clk,
   input wire logic [15:0] dbus_addr_q,
   input wire logic dbus_rd_q,
   output logic [7:0] dbus_rdata
);
   // ----
   // data valid while the strobe stands, scrambled otherwise
   // ----
   logic [7:0] idle_q;
   initial idle_q = 8'h00;
   always @(posedge core_clk)
      idle_q <= ~idle_q;
   assign dbus_rdata = dbus_rd_q ?
      dbus_addr_q[7:0] ^ dbus_addr_q[15:8] ^ 8'h3c : idle_q;
endmodule // bsle_mem_model

// File: sim/bsle_core_checker.sv
`timescale 1ns/1ps
module bsle_core_checker (
   // watched ports
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic instr_valid,
   input wire logic [5:0] instr_op,
   input wire logic [6:0] instr_k,
   input wire logic [15:0] instr_addr,
   input wire logic instr_ready_q,
   input wire logic done_q,
   input wire logic [15:0] pc_q,
   input wire logic [7:0] status_flags_register_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic go;
   logic [15:0] kx;
   assign go = instr_valid && instr_ready_q;
   assign kx = {{9{instr_k[6]}}, instr_k};
   // ----
   // timing and targets
   // ----
   cmp_time_a: assert property (go && instr_op == 6'h01 |-> ##2 done_q)
      else $error("compare late");
   br_taken_a: assert property (go && instr_op == 6'h0a && status_flags_register_q[1] |->
      ##3 done_q && pc_q == $past(pc_q, 3) + $past(kx, 3) + 16'h0001)
      else $error("taken branch wrong");
   br_untaken_a: assert property (go && instr_op == 6'h0b && status_flags_register_q[1]
      |-> ##2 done_q) else $error("untaken branch late");
   br_flags_a: assert property (go && instr_op >= 6'h08 &&
      instr_op <= 6'h1b |=> $stable(status_flags_register_q)[*2]) else $error("flags moved");
   direct_time_a: assert property (go && instr_op == 6'h1c |-> ##3 done_q)
      else $error("direct fetch late");
   inc_time_a: assert property (go && instr_op == 6'h1e |-> ##3 done_q)
      else $error("post increment late");
   dec_time_a: assert property (go && instr_op == 6'h1f |-> ##4 done_q)
      else $error("pre decrement late");
   call_pc_a: assert property (go && instr_op == 6'h20 |->
      ##4 done_q && pc_q == $past(instr_addr, 4)) else $error("call wrong");
   cover property (go && instr_op == 6'h0a && status_flags_register_q[1]);
   cover property (go && instr_op == 6'h1f);
   cover property (go && instr_op == 6'h07);
endmodule // bsle_core_checker
bind bsle_core bsle_core_checker i_chk (.*);

// File: sim/branch_skip_load_exec_bench.sv
`timescale 1ns/1ps
module branch_skip_load_exec_bench;
   logic core_clk, nrst, instr_valid, next_two_word, ext_wr_en, status_flags_register_wr_en;
   logic instr_ready_q, done_q, dbus_rd_q, t;
   logic [5:0] instr_op, op;
   logic [4:0] instr_d, instr_r, ext_wr_addr;
   logic [7:0] instr_imm, ext_wr_data, status_flags_register_wr_data, dbus_rdata, status_flags_register_q;
   logic [7:0] sr, a, b, c;
   logic [2:0] instr_bit;
   logic [6:0] instr_k;
   logic [15:0] instr_addr, pc_q, dbus_addr_q, pc, x;
   logic [1:0] instr_ptr;
   logic [31:0] rnd;
   logic [39:0] q[$];
   int cyc, mismatches, checked, seed;
   bsle_core i_dut (.*);
   bsle_mem_model i_mem (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   function automatic logic [7:0] m(input logic [15:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'h3c;
   endfunction
   function automatic logic [7:0] cf(input logic [7:0] d, r, input logic ci, zk);
      logic [8:0] s;
      logic [7:0] f;
      s = {1'b0, d} - {1'b0, r} - {8'h00, ci};
      f = sr;
      f[0] = s[8];
      f[1] = (s[7:0] == 8'h00) && (!zk || sr[1]);
      f[2] = s[7];
      f[3] = (d[7] != r[7]) && (s[7] != d[7]);
      f[4] = f[2] ^ f[3];
      f[5] = {1'b0, d[3:0]} < {1'b0, r[3:0]} + {4'h0, ci};
      return f;
   endfunction
   function automatic logic tk(input int i, input logic [2:0] s, input logic [7:0] f);
      int fi[20] = '{0, 0, 1, 1, 0, 0, 0, 0, 2, 2, 4, 4, 5, 5, 6, 6, 3, 3, 7, 7};
      bit ps[20] = '{1, 0, 1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0};
      if (i > 1)
         f[4] = f[2] ^ f[3];
      return f[i < 2 ? int'(s) : fi[i]] == ps[i];
   endfunction
   task automatic chk(input string n, input logic [39:0] s, e);
      checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      mismatches += q.size();
      if (mismatches == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic pre(input logic f, input logic [4:0] r, input logic [7:0] v);
      @(negedge core_clk);
      ext_wr_en = ~f;
      status_flags_register_wr_en = f;
      ext_wr_addr = r;
      ext_wr_data = v;
      status_flags_register_wr_data = v;
      @(negedge core_clk);
      {ext_wr_en, status_flags_register_wr_en} = 2'b00;
      if (f)
         sr = v;
   endtask
   // issue one instruction and note cycle, pc and flags expected
   task automatic run(input logic [5:0] o, input int n, input logic [15:0] np);
      int w;
      @(negedge core_clk);
      instr_op = o;
      instr_valid = 1'b1;
      q.push_back({16'(cyc + n), np, sr});
      @(negedge core_clk);
      instr_valid = 1'b0;
      pc = np;
      for (w = 0; w < 20 && q.size() > 0; w++)
         @(negedge core_clk);
   endtask
   task automatic chkreg(input logic [4:0] r, input logic [7:0] v);
      instr_d = r;
      instr_imm = v;
      sr = cf(v, v, 1'b0, 1'b0);
      run(6'h03, 2, pc + 16'h0001);
   endtask
   always @(negedge core_clk)
      if (done_q === 1'b1)
         chk("result", {cyc[15:0], pc_q, status_flags_register_q}, q.pop_front());
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         mismatches++;
         stop_test;
      end
   end
   initial
   begin
      seed = 32'h6a2a;
      {nrst, instr_valid, next_two_word, ext_wr_en, status_flags_register_wr_en} = 5'h00;
      {instr_op, instr_d, instr_r, instr_imm, instr_bit, instr_k} = '0;
      {instr_addr, instr_ptr, ext_wr_addr, ext_wr_data, status_flags_register_wr_data} = '0;
      {pc, sr} = '0;
      repeat (3) @(negedge core_clk);
      nrst = 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         rnd = $random(seed);
         pre(0, 5'h01, rnd[7:0]);
         pre(0, 5'h02, rnd[15:8]);
         pre(1, 5'h00, rnd[23:16]);
         {instr_d, instr_r, instr_imm} = {5'h01, 5'h02, rnd[15:8]};
         sr = cf(rnd[7:0], rnd[15:8], i % 3 == 1 && sr[0], i % 3 == 1);
         run(6'(1 + i % 3), 2, pc + 16'h0001);
      end
      for (int i = 0; i < 40; i++)
      begin
         rnd = $random(seed);
         pre(1, 5'h00, rnd[7:0]);
         {instr_k, instr_bit} = rnd[17:8];
         t = tk(i % 20, instr_bit, sr);
         run(6'(8 + i % 20), t ? 3 : 2, t ? pc + {{9{instr_k[6]}}, instr_k} + 16'h0001
            : pc + 16'h0001);
      end
      for (int i = 0; i < 20; i++)
      begin
         rnd = $random(seed);
         op = i % 5 == 0 ? 6'h00 : 6'(3 + i % 5);
         a = rnd[7:0];
         b = i % 2 ? a : rnd[15:8];
         pre(0, 5'h03, a);
         pre(0, 5'h04, b);
         {instr_d, instr_r, instr_bit, next_two_word} = {10'h064, rnd[18:16], rnd[19]};
         instr_addr = {11'h000, rnd[24:20]};
         c = op < 6'h06 ? b : m(instr_addr);
         t = op == 6'h00 ? a == b : c[instr_bit] == op[0];
         run(op, (op > 6'h05 ? 3 : 2) + (t ? 1 + next_two_word : 0),
            pc + (t ? 16'h0002 + next_two_word : 16'h0001));
      end
      for (int i = 0; i < 3; i++)
      begin
         rnd = $random(seed);
         x = rnd[15:0];
         pre(0, 5'(26 + 2 * i), x[7:0]);
         pre(0, 5'(27 + 2 * i), x[15:8]);
         {instr_ptr, instr_d, instr_addr} = {2'(i), 5'h05, rnd[31:16]};
         run(6'h1c, 3, pc + 16'h0002);
         chkreg(5'h05, m(instr_addr));
         instr_d = 5'h06;
         run(6'h1e, 3, pc + 16'h0001);
         chkreg(5'h06, m(x));
         instr_d = 5'h07;
         run(6'h1e, 3, pc + 16'h0001);
         chkreg(5'h07, m(x + 16'h0001));
         instr_d = 5'h08;
         run(6'h1f, 4, pc + 16'h0001);
         chkreg(5'h08, m(x + 16'h0001));
      end
      rnd = $random(seed);
      instr_addr = rnd[15:0];
      run(6'h20, 4, instr_addr);
      sr[7] = 1'b1;
      run(6'h22, 5, {m(16'h1000), m(16'h1001)});
      stop_test;
   end
endmodule // branch_skip_load_exec_bench
